// ### irq_routing_init_control.sv
// Interrupt latch/routing, boot commands, feature port and halt error flags
//
// Summary of operation
// - Hold bit 0 selects latched or following interrupts
// - Route bit 0 sends FIFO full to A
// - Route bit 1 sends watermark to A
// - Route bit 2 sends data ready to A
// - Route bit 4 sends FIFO full to B
// - Route bit 5 sends watermark to B
// - Route bit 6 sends data ready to B
// - Command 0x00 opens configuration file download
// - Command 0x01 starts init, activates features
// - Feature port is 8-bit read/write, reset zero
// - Timeout sets error bit 1 and halts
// - Fatal error sets error bit 2 and halts
// - Polarity bit: 0 active low, 1 high
// - Pin drives only while output enable set
`timescale 1ns/1ns
`include "iric_regs.svh"

module irq_routing_init_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Interrupt sources and their status clears
    input wire iric_pkg::iric_src_t srcLevel,
    input wire iric_pkg::iric_src_t srcClear,
    // Pin electrical setup
    input wire iric_pkg::iric_pin_cfg_t pinACfg,
    input wire iric_pkg::iric_pin_cfg_t pinBCfg,
    // Internal processing errors
    input wire logic procTimeout,
    input wire logic procFatal,
    // Interrupt pins
    output logic irqPinA,
    output logic irqPinAOe,
    output logic irqPinB,
    output logic irqPinBOe,
    // Initialization and feature side
    output logic cfgLoadMode,
    output logic featuresActive,
    output logic processingHalted,
    output logic featWrStrobe,
    output logic [7:0] featWrData
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] holdCfg;
    logic [7:0] dataRoute;
    logic [7:0] pinAFeat;
    logic [7:0] pinBFeat;
    logic [7:0] bootCmd;
    logic [7:0] featPort;
    logic [7:0] haltErr;
    iric_pkg::iric_src_t srcHeld;
    iric_pkg::iric_boot_t bootState;
    iric_pkg::iric_boot_t next_bootState;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic wrHold = regWrEn && regAddr == `IRIC_OFF_HOLD;
    wire logic wrRoute = regWrEn && regAddr == `IRIC_OFF_DATA_ROUTE;
    wire logic wrPinA = regWrEn && regAddr == `IRIC_OFF_PIN_A_FEAT;
    wire logic wrPinB = regWrEn && regAddr == `IRIC_OFF_PIN_B_FEAT;
    wire logic wrBoot = regWrEn && regAddr == `IRIC_OFF_BOOT_CMD;
    wire logic wrFeat = regWrEn && regAddr == `IRIC_OFF_FEAT_PORT;
    wire logic latchMode = holdCfg[`IRIC_BIT_LATCH];

    // Set wins over clear so a source arriving with its clear is kept
    wire iric_pkg::iric_src_t next_srcHeld = srcLevel | (srcHeld & ~srcClear);
    // Latched view holds until cleared; otherwise the live level
    wire iric_pkg::iric_src_t srcView = latchMode ? srcHeld : srcLevel;

    wire logic pinAEvent = (dataRoute[`IRIC_BIT_A_FULL] & srcView.fifoFull)
        | (dataRoute[`IRIC_BIT_A_WM] & srcView.watermark)
        | (dataRoute[`IRIC_BIT_A_DRDY] & srcView.dataReady);
    wire logic pinBEvent = (dataRoute[`IRIC_BIT_B_FULL] & srcView.fifoFull)
        | (dataRoute[`IRIC_BIT_B_WM] & srcView.watermark)
        | (dataRoute[`IRIC_BIT_B_DRDY] & srcView.dataReady);

    // Pin level from polarity; a disabled pin idles at its inactive level
    function automatic logic pin_level(input logic ev, input iric_pkg::iric_pin_cfg_t cfg);
        pin_level = cfg.activeHigh ? (ev & cfg.outputEnable) : ~(ev & cfg.outputEnable);
    endfunction

    wire logic next_pinA = pin_level(pinAEvent, pinACfg);
    wire logic next_pinB = pin_level(pinBEvent, pinBCfg);

    wire logic [7:0] next_haltErr = haltErr
        | ({7'h00, procTimeout} << `IRIC_BIT_ERR_TIME)
        | ({7'h00, procFatal} << `IRIC_BIT_ERR_FATAL);

    wire logic [7:0] rdMux =
        regAddr == `IRIC_OFF_HOLD ? holdCfg :
        regAddr == `IRIC_OFF_PIN_A_FEAT ? pinAFeat :
        regAddr == `IRIC_OFF_PIN_B_FEAT ? pinBFeat :
        regAddr == `IRIC_OFF_DATA_ROUTE ? dataRoute :
        regAddr == `IRIC_OFF_BOOT_CMD ? bootCmd :
        regAddr == `IRIC_OFF_FEAT_PORT ? featPort :
        regAddr == `IRIC_OFF_HALT_ERR ? haltErr : 8'h00;

    // ----------------------------------------------------------------
    // Boot sequencing
    // ----------------------------------------------------------------
    // A repeated command is not refused; the host keeps the once-only order
    always_comb begin
        next_bootState = bootState;
        unique case (bootState)
            iric_pkg::BOOT_IDLE: begin
                if (wrBoot && regWrData == `IRIC_CMD_LOAD_CFG) begin
                    next_bootState = iric_pkg::BOOT_LOAD;
                end
            end
            iric_pkg::BOOT_LOAD: begin
                if (wrBoot && regWrData == `IRIC_CMD_START_INIT) begin
                    next_bootState = iric_pkg::BOOT_ACTIVE;
                end
            end
            iric_pkg::BOOT_ACTIVE: begin
            end
            iric_pkg::BOOT_HALTED: begin
            end
            default: next_bootState = iric_pkg::BOOT_IDLE;
        endcase
        if (next_haltErr != 8'h00) begin
            next_bootState = iric_pkg::BOOT_HALTED;
        end
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            holdCfg <= `IRIC_RST_HOLD;
            dataRoute <= `IRIC_RST_ROUTE;
            pinAFeat <= `IRIC_RST_ROUTE;
            pinBFeat <= `IRIC_RST_ROUTE;
            bootCmd <= `IRIC_RST_BOOT_CMD;
            featPort <= `IRIC_RST_FEAT;
            haltErr <= 8'h00;
            srcHeld <= '0;
            bootState <= iric_pkg::BOOT_IDLE;
        end else begin
            if (wrHold) holdCfg <= regWrData & `IRIC_MASK_HOLD;
            if (wrRoute) dataRoute <= regWrData & `IRIC_MASK_ROUTE;
            if (wrPinA) pinAFeat <= regWrData;
            if (wrPinB) pinBFeat <= regWrData;
            if (wrBoot) bootCmd <= regWrData;
            if (wrFeat) featPort <= regWrData;
            haltErr <= next_haltErr;
            srcHeld <= next_srcHeld;
            bootState <= next_bootState;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 8'h00;
            irqPinA <= 1'b1;
            irqPinB <= 1'b1;
            irqPinAOe <= 1'b0;
            irqPinBOe <= 1'b0;
            cfgLoadMode <= 1'b0;
            featuresActive <= 1'b0;
            processingHalted <= 1'b0;
            featWrStrobe <= 1'b0;
            featWrData <= 8'h00;
        end else begin
            regRdData <= regRdEn ? rdMux : 8'h00;
            irqPinA <= next_pinA;
            irqPinB <= next_pinB;
            irqPinAOe <= pinACfg.outputEnable;
            irqPinBOe <= pinBCfg.outputEnable;
            cfgLoadMode <= next_bootState == iric_pkg::BOOT_LOAD;
            featuresActive <= next_bootState == iric_pkg::BOOT_ACTIVE;
            processingHalted <= next_bootState == iric_pkg::BOOT_HALTED;
            featWrStrobe <= wrFeat;
            featWrData <= wrFeat ? regWrData : featWrData;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_load_cmd;
        wrBoot && regWrData == `IRIC_CMD_LOAD_CFG && bootState == iric_pkg::BOOT_IDLE
            && next_haltErr == 8'h00;
    endsequence
    sequence s_start_cmd;
        wrBoot && regWrData == `IRIC_CMD_START_INIT && bootState == iric_pkg::BOOT_LOAD
            && next_haltErr == 8'h00;
    endsequence

    a_latch_mode_bit: assert property (wrHold |=> latchMode == $past(regWrData[0]))
        else $error("Latch mode bit not taken from write");
    a_latched_hold: assert property (latchMode && srcHeld.fifoFull && !srcClear.fifoFull
        && !wrHold |=> srcHeld.fifoFull)
        else $error("Latched source dropped without clear");
    a_pin_a_full: assert property (dataRoute[0] && !latchMode && srcLevel.fifoFull
        && pinACfg == 2'b11 |=> irqPinA)
        else $error("FIFO full not on pin A");
    a_pin_a_wm: assert property (dataRoute[1] && !latchMode && srcLevel.watermark
        && pinACfg == 2'b11 |=> irqPinA)
        else $error("Watermark not on pin A");
    a_pin_a_drdy: assert property (dataRoute[2] && !latchMode && srcLevel.dataReady
        && pinACfg == 2'b10 |=> !irqPinA)
        else $error("Data ready not on active-low pin A");
    a_pin_b_full: assert property (dataRoute[4] && !latchMode && srcLevel.fifoFull
        && pinBCfg == 2'b11 |=> irqPinB)
        else $error("FIFO full not on pin B");
    a_pin_b_wm: assert property (dataRoute[5] && !latchMode && srcLevel.watermark
        && pinBCfg == 2'b11 |=> irqPinB)
        else $error("Watermark not on pin B");
    a_pin_b_drdy: assert property (dataRoute[6] && !latchMode && srcLevel.dataReady
        && pinBCfg == 2'b11 |=> irqPinB)
        else $error("Data ready not on pin B");
    a_boot_load: assert property (s_load_cmd |=> cfgLoadMode && !featuresActive)
        else $error("Load command did not open download");
    // An error right after start may legally halt the features
    a_boot_start: assert property (s_start_cmd |=> featuresActive ##1 (featuresActive || processingHalted))
        else $error("Start command did not activate features");
    a_feat_port: assert property (wrFeat |=> featPort == $past(regWrData) && featWrStrobe)
        else $error("Feature port write lost");
    a_err_timeout: assert property (procTimeout |=> haltErr[1] ##1 processingHalted)
        else $error("Timeout did not halt");
    a_err_fatal: assert property (procFatal |=> haltErr[2] && processingHalted)
        else $error("Fatal error did not halt");
    a_pin_disabled: assert property (!pinBCfg.outputEnable |=> !irqPinBOe)
        else $error("Pin B driven while disabled");

endmodule

// ### iric_regs.svh
// Register offsets, field positions, reset values and masks of the interrupt routing block
`ifndef IRIC_REGS_SVH
`define IRIC_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define IRIC_OFF_HOLD 8'h55
`define IRIC_OFF_PIN_A_FEAT 8'h56
`define IRIC_OFF_PIN_B_FEAT 8'h57
`define IRIC_OFF_DATA_ROUTE 8'h58
`define IRIC_OFF_BOOT_CMD 8'h59
`define IRIC_OFF_FEAT_PORT 8'h5E
`define IRIC_OFF_HALT_ERR 8'h5F

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define IRIC_RST_HOLD 8'h00
`define IRIC_RST_ROUTE 8'h00
`define IRIC_RST_BOOT_CMD 8'h90
`define IRIC_RST_FEAT 8'h00
`define IRIC_MASK_HOLD 8'h01
`define IRIC_MASK_ROUTE 8'h77

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define IRIC_BIT_LATCH 0
`define IRIC_BIT_A_FULL 0
`define IRIC_BIT_A_WM 1
`define IRIC_BIT_A_DRDY 2
`define IRIC_BIT_B_FULL 4
`define IRIC_BIT_B_WM 5
`define IRIC_BIT_B_DRDY 6
`define IRIC_BIT_ERR_TIME 1
`define IRIC_BIT_ERR_FATAL 2

// ----------------------------------------------------------------
// Boot commands
// ----------------------------------------------------------------
`define IRIC_CMD_LOAD_CFG 8'h00
`define IRIC_CMD_START_INIT 8'h01

`endif

// ### iric_pkg.sv
// Types shared by the interrupt routing and initialization control block
package iric_pkg;

    // Data-path interrupt sources, one bit each
    typedef struct packed {
        logic dataReady;
        logic watermark;
        logic fifoFull;
    } iric_src_t;

    // Electrical setup of one interrupt pin
    typedef struct packed {
        logic outputEnable;
        logic activeHigh;
    } iric_pin_cfg_t;

    // Initialization progress, one-hot
    typedef enum logic [3:0] {
        BOOT_IDLE   = 4'h1,
        BOOT_LOAD   = 4'h2,
        BOOT_ACTIVE = 4'h4,
        BOOT_HALTED = 4'h8
    } iric_boot_t;

endpackage

// ### iric_host_model.sv
// Host model driving the register port, one-shot boot commands
`timescale 1ns/1ns
module iric_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    bit [1:0] issued = 2'h0;
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'h0;
        regWrData = 8'h00;
        regRdEn = 1'h0;
    end
    // Released lines show inverted data so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        @(negedge clk);
        regWrEn = 1'h0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'h1;
        @(negedge clk);
        regRdEn = 1'h0;
        regAddr = ~a;
        d = regRdData;
    endtask
    task automatic boot(input logic [7:0] cmd);
        if (!issued[cmd[0]]) begin
            issued[cmd[0]] = 1'h1;
            wr(8'h59, cmd);
        end
    endtask
    task automatic forget();
        issued = 2'h0;
    endtask
endmodule

// ### test_irq_routing_init_control.sv
// Self-checking bench of the interrupt routing and init control block
`timescale 1ns/1ns
module test_irq_routing_init_control;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] regAddr, regWrData, regRdData, featWrData, rv, d, rt;
    logic regWrEn, regRdEn, procTimeout = 1'h0, procFatal = 1'h0;
    logic irqPinA, irqPinAOe, irqPinB, irqPinBOe, cfgLoadMode, featuresActive;
    logic processingHalted, featWrStrobe;
    iric_pkg::iric_src_t srcLevel = 3'h0, srcClear = 3'h0;
    iric_pkg::iric_pin_cfg_t pinACfg = 2'h0, pinBCfg = 2'h0;
    logic [2:0] lat = 3'h0;
    int errors = 0, nTests = 0;
    logic [7:0] offs [8] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5E, 8'h5F, 8'h5A};
    logic [7:0] rsts [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h00, 8'h00};
    logic [7:0] wmask [8] = '{8'h01, 8'hFF, 8'hFF, 8'h77, 8'hFF, 8'hFF, 8'h00, 8'h00};
    always #20 clk = ~clk;
    irq_routing_init_control DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .srcLevel(srcLevel), .srcClear(srcClear), .pinACfg(pinACfg), .pinBCfg(pinBCfg),
        .procTimeout(procTimeout), .procFatal(procFatal), .irqPinA(irqPinA),
        .irqPinAOe(irqPinAOe), .irqPinB(irqPinB), .irqPinBOe(irqPinBOe),
        .cfgLoadMode(cfgLoadMode), .featuresActive(featuresActive),
        .processingHalted(processingHalted), .featWrStrobe(featWrStrobe),
        .featWrData(featWrData));
    iric_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
    // ------------------------------------------------------------
    // Checking helpers and reference model
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Disabled pin parks at its inactive level
    function automatic logic [1:0] pinExp(input logic act, input iric_pkg::iric_pin_cfg_t c);
        return {c.outputEnable, (c.outputEnable & act) ? c.activeHigh : ~c.activeHigh};
    endfunction
    task automatic step(input logic [7:0] route, input logic latched);
        logic [2:0] act;
        @(negedge clk);
        srcLevel = 3'($urandom);
        srcClear = 3'($urandom);
        pinACfg = 2'($urandom);
        pinBCfg = 2'($urandom);
        @(posedge clk);
        // Latched pins show the held copy from before this edge
        act = latched ? lat : srcLevel;
        lat = srcLevel | (lat & ~srcClear);
        @(negedge clk);
        check("pin A", 8'(pinExp(|(act & route[2:0]), pinACfg)), 8'({irqPinAOe, irqPinA}));
        check("pin B", 8'(pinExp(|(act & route[6:4]), pinBCfg)), 8'({irqPinBOe, irqPinB}));
        srcLevel = 3'h0;
        srcClear = 3'h0;
    endtask
    task automatic flushLatch();
        @(negedge clk);
        srcClear = 3'h7;
        @(negedge clk);
        srcClear = 3'h0;
        lat = 3'h0;
    endtask
    task automatic resetDut();
        rstn = 1'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'h1;
        host.forget();
    endtask
    task automatic errHit(input logic fatal);
        @(negedge clk);
        procFatal = fatal;
        procTimeout = ~fatal;
        @(negedge clk);
        procFatal = 1'h0;
        procTimeout = 1'h0;
        check("halt state", 8'h02, 8'({processingHalted, featuresActive}));
        host.rd(8'h5F, rv);
        check("error flags", fatal ? 8'h04 : 8'h02, rv);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        #(40 * 40000);
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h8e63));
        resetDut();
        for (int i = 0; i < 8; i++) begin
            host.rd(offs[i], rv);
            check("reset value", rsts[i], rv);
        end
        $display("test reset values done");
        // Bit 7 forced so a boot write is never a command
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) | 8'h80;
            host.wr(offs[i], d);
            if (offs[i] == 8'h5E) begin
                check("feature strobe", 8'h01, 8'(featWrStrobe));
                check("feature data", d, featWrData);
            end
            host.rd(offs[i], rv);
            check("readback", d & wmask[i], rv);
        end
        $display("test register access done");
        for (int m = 0; m < 2; m++) begin
            host.wr(8'h55, 8'(m));
            flushLatch();
            for (int r = 0; r < 12; r++) begin
                rt = 8'($urandom) & 8'h77;
                host.wr(8'h58, rt);
                repeat (10) step(rt, m[0]);
            end
            $display("test routing mode %0d done", m);
        end
        host.boot(8'h00);
        check("load mode", 8'h01, 8'({featuresActive, cfgLoadMode}));
        host.boot(8'h01);
        check("features", 8'h02, 8'({featuresActive, cfgLoadMode}));
        errHit(1'h0);
        resetDut();
        host.boot(8'h01);
        check("early start", 8'h00, 8'({featuresActive, cfgLoadMode}));
        errHit(1'h1);
        $display("test boot and errors done");
        wrap_up();
    end
endmodule
